// [hw/spms_cfg.svh]
/*
  Constants of the serial master/slave port: FIFO shape, word-size limits,
  interrupt source positions and frame-format codes.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Behaviour
// - Port works as master or slave, in chip-select or frame-sync format.
// - Transmit and receive paths each have a 32 by 16-bit FIFO.
// - Bits leave on the data output, arrive on data input, form words.
// - Serial clock comes from kernel clock via prescaler then bit-rate divider.
// - Frame format and word size come from per-slave settings; mode is global.
// - Combined interrupt is high while any unmasked source is active.
// - Selects are active-high sync pulses in frame-sync, active-low selects otherwise.
// - Frames carry the programmed 4 to 16 bits, most significant first.
// - Master drives clock and selects; slave takes them as inputs.
// - Slave uses only select zero; other selects are ignored.
// - Master serial clock never exceeds half the kernel clock.
// - Register side and rate divisor run on the one core clock.
// - Master addresses up to four slaves in turn, one select each.
// - Transmit, receive and overrun interrupt sources each have a mask.
// - Loopback feeds the sent stream to the receiver in place of the data input; the data output still carries it.
`ifndef SPMS_CFG_SVH
`define SPMS_CFG_SVH
`define SPMS_WORD_W 16
`define SPMS_FIFO_DEPTH 32
`define SPMS_NUM_SLV 4
`define SPMS_WS_MIN 4
`define SPMS_WS_MAX 16
`define SPMS_PRE_W 8
`define SPMS_DIV_W 8
`define SPMS_IRQ_TX 0
`define SPMS_IRQ_RX 1
`define SPMS_IRQ_OVR 2
`define SPMS_FMT_SPI 1'b0
`define SPMS_FMT_SSI 1'b1
`endif

// [hw/spms_pkg.sv]
/*
  Types shared by the serial port modules.
  Assumes spms_cfg.svh is on the include path.
*/
package spms_pkg;
`include "spms_cfg.svh"
  typedef logic [`SPMS_WORD_W-1:0] spms_word_t;
  // Gray codes along idle, setup, shift, done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_SHIFT = 2'b11,
    ST_DONE = 2'b10
  } spms_state_e;
endpackage

// [hw/spms_fifo.sv]
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module spms_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  assign o_ready = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
  assign o_valid = wp_q != rp_q;
  assign o_data = mem_q[rp_q[AW-1:0]];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= i_data;
    end
  end

  chk_fifo_depth: assert property (@(posedge i_clk) disable iff (i_srst)
    (AW+1)'(wp_q - rp_q) <= (AW+1)'(DEPTH)) else $error("FIFO holds more than its depth");
endmodule // spms_fifo

// [hw/spms_clkdiv.sv]
/*
  Prescaler followed by bit-rate divider; one-cycle tick per serial half period.
  Assumes restart is held while no frame runs, so ticks align to frame start.
*/
`timescale 1ns/1ps
module spms_clkdiv #(
  parameter int PW = 8,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Control
  input wire logic i_restart,
  input wire logic [PW-1:0] i_prescale,
  input wire logic [DW-1:0] i_divisor,
  // Half-period enable
  output logic o_tick
);
  if (PW < 1 || DW < 1) begin : g_bad_width
    $error("divider widths must be positive");
  end
  logic [PW-1:0] pre_q, pre_d;
  logic [DW-1:0] div_q, div_d;
  logic pre_end;

  // prescale then divide
  // Prescale of zero acts as one, so a tick is never faster than every cycle
  assign pre_end = (pre_q + 1'b1 >= i_prescale);
  assign o_tick = pre_end && (div_q >= i_divisor) && !i_restart;

  always_comb begin
    pre_d = pre_q;
    div_d = div_q;
    if (i_restart) begin
      pre_d = '0;
      div_d = '0;
    end else if (pre_end) begin
      pre_d = '0;
      div_d = o_tick ? '0 : div_q + 1'b1;
    end else begin
      pre_d = pre_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pre_q <= '0;
      div_q <= '0;
    end else begin
      pre_q <= pre_d;
      div_q <= div_d;
    end
  end

  // ticks never back to back when divided
  chk_tick_space: assert property (@(posedge i_clk) disable iff (i_srst)
    o_tick && (i_divisor != '0) |=> !o_tick) else $error("ticks closer than divisor allows");
endmodule // spms_clkdiv

// [hw/spms_top.sv]
/*
  Serial master/slave port: transmit and receive FIFOs, master frame engine
  with clock divider, slave frame engine, loopback and combined interrupt.
  Assumes one core clock; pins from outside are synchronised here.
*/
`timescale 1ns/1ps
`include "spms_cfg.svh"
module spms_top #(
  parameter int FIFO_DEPTH = `SPMS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // Global control
  input wire logic I_ENABLE,
  input wire logic I_MASTER,
  input wire logic I_LOOPBACK,
  input wire logic [`SPMS_PRE_W-1:0] I_PRESCALE,
  input wire logic [`SPMS_DIV_W-1:0] I_DIVISOR,
  // Per-slave settings
  input wire logic [`SPMS_NUM_SLV-1:0] I_SLV_EN,
  input wire logic [`SPMS_NUM_SLV-1:0] I_SLV_FMT,
  input wire logic [4*`SPMS_NUM_SLV-1:0] I_SLV_WSIZE,
  // Transmit FIFO fill side
  input wire logic I_TX_VALID,
  input wire spms_pkg::spms_word_t I_TX_DATA,
  output logic O_TX_READY,
  // Receive FIFO drain side
  output logic O_RX_VALID,
  output spms_pkg::spms_word_t O_RX_DATA,
  input wire logic I_RX_READY,
  // Interrupt
  input wire logic [2:0] I_IRQ_MASK,
  input wire logic I_OVR_CLR,
  output logic O_OVERRUN,
  output logic O_BUSY,
  output logic O_IRQ,
  // Serial pins
  output logic O_SDO,
  input wire logic I_SDI,
  input wire logic I_SCK,
  output logic O_SCK,
  output logic O_SCK_OE_N,
  input wire logic I_SEL0,
  output logic [`SPMS_NUM_SLV-1:0] O_SEL,
  output logic [`SPMS_NUM_SLV-1:0] O_SEL_OE_N
);
  import spms_pkg::*;
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("FIFO depth too small");
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Word size field holds bits minus one; codes below four clamp to four
  function automatic logic [4:0] f_bits(input logic [3:0] ws);
    f_bits = (ws < 4'(`SPMS_WS_MIN - 1)) ? 5'(`SPMS_WS_MIN) : 5'(ws) + 5'h01;
  endfunction
  function automatic spms_word_t f_align(input spms_word_t w, input logic [4:0] b);
    f_align = w << (5'(`SPMS_WS_MAX) - b);
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] pin_in, s1_q, s2_q, s3_q, flt_q, flt_d, prv_q;
  assign pin_in = {I_SEL0, I_SCK, I_SDI};
  // A change counts once the second and third stages agree
  always_comb begin
    flt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
  end
  always_ff @(posedge I_CORE_CLK) begin
    s1_q <= pin_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (I_SRST) begin
      flt_q <= 3'h4;
      prv_q <= 3'h4;
    end else begin
      flt_q <= flt_d;
      prv_q <= flt_q;
    end
  end

  // ************************************************************
  // FIFOs
  // ************************************************************
  logic tx_vld, tx_pop, rx_push, rx_rdy;
  spms_word_t tx_dat, rx_word;
  spms_fifo #(.W(`SPMS_WORD_W), .DEPTH(FIFO_DEPTH)) u_txf (
    .i_clk(I_CORE_CLK), .i_srst(I_SRST),
    .i_valid(I_TX_VALID), .i_data(I_TX_DATA), .o_ready(O_TX_READY),
    .o_valid(tx_vld), .o_data(tx_dat), .i_ready(tx_pop)
  );
  spms_fifo #(.W(`SPMS_WORD_W), .DEPTH(FIFO_DEPTH)) u_rxf (
    .i_clk(I_CORE_CLK), .i_srst(I_SRST),
    .i_valid(rx_push), .i_data(I_MASTER ? rxsh_q : rx_word), .o_ready(rx_rdy),
    .o_valid(O_RX_VALID), .o_data(O_RX_DATA), .i_ready(I_RX_READY)
  );

  // ************************************************************
  // Frame engines
  // ************************************************************
  spms_state_e st_q, st_d;
  logic sck_q, sck_d, sact_q, sact_d, srel_q, srel_d, tick, ovr_q, ovr_d;
  logic [1:0] cur_q, cur_d, nslv;
  logic [`SPMS_NUM_SLV-1:0] act_q, act_d;
  logic [4:0] cnt_q, cnt_d, bits_c, bits_n, bits_s, nrise_q, nrise_d;
  spms_word_t txsh_q, txsh_d, rxsh_q, rxsh_d;
  logic sdi_v, s_rise, s_fall, s_sel, fmt_c, fmt_s, s_start, s_stop;

  spms_clkdiv #(.PW(`SPMS_PRE_W), .DW(`SPMS_DIV_W)) u_div (
    .i_clk(I_CORE_CLK), .i_srst(I_SRST),
    .i_restart(st_q == ST_IDLE || !I_MASTER),
    .i_prescale(I_PRESCALE), .i_divisor(I_DIVISOR), .o_tick(tick)
  );

  always_comb begin
    nslv = cur_q;
    for (int k = 3; k >= 1; k--) begin
      if (I_SLV_EN[2'(cur_q + 2'(k))]) begin
        nslv = 2'(cur_q + 2'(k));
      end
    end
    if (I_SLV_EN == '0) begin
      nslv = 2'h0;
    end
  end

  assign bits_n = f_bits(I_SLV_WSIZE[4*nslv +: 4]);
  assign bits_c = f_bits(I_SLV_WSIZE[4*cur_q +: 4]);
  assign fmt_c = I_SLV_FMT[cur_q];
  assign bits_s = f_bits(I_SLV_WSIZE[3:0]);
  assign fmt_s = I_SLV_FMT[0];
  assign s_sel = flt_q[2];
  assign s_rise = flt_q[1] && !prv_q[1];
  assign s_fall = !flt_q[1] && prv_q[1];
  assign sdi_v = I_LOOPBACK ? txsh_q[`SPMS_WORD_W-1] : flt_q[0];
  assign s_start = (fmt_s == `SPMS_FMT_SSI) ? (s_fall && s_sel) : (!s_sel && !sact_q);
  assign s_stop = (fmt_s == `SPMS_FMT_SSI) ? (s_fall && srel_q && !s_sel) : s_sel;
  assign rx_word = {rxsh_q[`SPMS_WORD_W-2:0], sdi_v};

  always_comb begin
    st_d = st_q;
    sck_d = sck_q;
    act_d = act_q;
    cur_d = cur_q;
    cnt_d = cnt_q;
    txsh_d = txsh_q;
    rxsh_d = rxsh_q;
    sact_d = sact_q;
    srel_d = srel_q;
    nrise_d = (st_q == ST_IDLE) ? 5'h00 : nrise_q;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    if (!I_ENABLE) begin
      st_d = ST_IDLE;
      sck_d = 1'b0;
      act_d = '0;
      sact_d = 1'b0;
      srel_d = 1'b0;
    end else if (I_MASTER) begin
      sact_d = 1'b0;
      srel_d = 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          sck_d = 1'b0;
          if (tx_vld) begin
            tx_pop = 1'b1;
            cur_d = nslv;
            txsh_d = f_align(tx_dat, bits_n);
            rxsh_d = '0;
            cnt_d = 5'h00;
            act_d = 4'(1) << nslv;
            st_d = ST_SETUP;
          end
        end
        ST_SETUP: begin
          // frame pulse one bit period ahead of the first bit
          if (tick && fmt_c == `SPMS_FMT_SSI) begin
            sck_d = !sck_q;
            if (sck_q) begin
              act_d = '0;
              st_d = ST_SHIFT;
            end
          end else if (tick) begin
            st_d = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // sample on rise, shift on fall
          if (tick && !sck_q) begin
            sck_d = 1'b1;
            rxsh_d = rx_word;
            nrise_d = nrise_q + 5'h01;
          end else if (tick) begin
            sck_d = 1'b0;
            if (cnt_q == bits_c - 5'h01) begin
              rx_push = 1'b1;
              st_d = ST_DONE;
            end else begin
              cnt_d = cnt_q + 5'h01;
              txsh_d = txsh_q << 1;
            end
          end
        end
        ST_DONE: begin
          // Deselect gap of one half period between frames
          act_d = '0;
          if (tick) begin
            st_d = ST_IDLE;
          end
        end
      endcase
    end else begin
      st_d = ST_IDLE;
      sck_d = 1'b0;
      act_d = '0;
      // edges detectable only at a quarter of the core rate
      if (s_stop) begin
        sact_d = 1'b0;
        srel_d = 1'b0;
      end else if (s_start || (sact_q && s_fall && srel_q)) begin
        sact_d = 1'b1;
        srel_d = 1'b0;
        tx_pop = tx_vld;
        txsh_d = tx_vld ? f_align(tx_dat, bits_s) : '0;
        rxsh_d = '0;
        cnt_d = 5'h00;
      end else if (sact_q && s_rise) begin
        rxsh_d = rx_word;
        if (cnt_q == bits_s - 5'h01) begin
          rx_push = 1'b1;
          srel_d = 1'b1;
          cnt_d = 5'h00;
        end else begin
          cnt_d = cnt_q + 5'h01;
        end
      end else if (sact_q && s_fall) begin
        txsh_d = txsh_q << 1;
      end
    end
  end

  // set wins over clear; dropped word never enters the FIFO
  always_comb begin
    ovr_d = (ovr_q && !I_OVR_CLR) || (rx_push && !rx_rdy);
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      st_q <= ST_IDLE;
      sck_q <= 1'b0;
      act_q <= '0;
      cur_q <= 2'h3;
      cnt_q <= 5'h00;
      txsh_q <= '0;
      rxsh_q <= '0;
      sact_q <= 1'b0;
      srel_q <= 1'b0;
      ovr_q <= 1'b0;
      nrise_q <= 5'h00;
    end else begin
      st_q <= st_d;
      sck_q <= sck_d;
      act_q <= act_d;
      cur_q <= cur_d;
      cnt_q <= cnt_d;
      txsh_q <= txsh_d;
      rxsh_q <= rxsh_d;
      sact_q <= sact_d;
      srel_q <= srel_d;
      ovr_q <= ovr_d;
      nrise_q <= nrise_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic [2:0] irq_src;
  // sources: transmit empty, receive pending, overrun
  assign irq_src = {ovr_q, O_RX_VALID, !tx_vld};
  assign O_IRQ = |(irq_src & ~I_IRQ_MASK);
  assign O_OVERRUN = ovr_q;
  assign O_BUSY = (st_q != ST_IDLE) || sact_q;
  assign O_SDO = txsh_q[`SPMS_WORD_W-1];
  assign O_SCK = sck_q;
  // drive only as master; low enable means driving
  assign O_SCK_OE_N = !I_MASTER;
  assign O_SEL_OE_N = {`SPMS_NUM_SLV{!I_MASTER}};
  assign O_SEL = (act_q & I_SLV_FMT) | (~act_q & ~I_SLV_FMT);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);
  sequence s_frame_start;
    st_q == ST_IDLE ##1 st_q == ST_SETUP;
  endsequence
  sequence s_ssi_pulse;
    (st_q == ST_SETUP && fmt_c == `SPMS_FMT_SSI)[*2];
  endsequence

  chk_irq_combine: assert property (O_IRQ == |(irq_src & ~I_IRQ_MASK))
    else $error("interrupt does not match unmasked sources");
  chk_overrun_set: assert property (rx_push && !rx_rdy |=> O_OVERRUN)
    else $error("overrun not raised on full receive FIFO");
  chk_start_data: assert property (s_frame_start |-> $past(tx_vld))
    else $error("frame started without transmit data");
  chk_idle_clock: assert property (st_q == ST_IDLE |-> !O_SCK)
    else $error("serial clock active while idle");
  chk_clock_rate: assert property (I_ENABLE && I_MASTER && sck_d != sck_q |-> tick)
    else $error("serial clock moved without a divider tick");
  chk_pin_dir: assert property (O_SCK_OE_N == !I_MASTER && O_SEL_OE_N[0] == !I_MASTER)
    else $error("pin direction does not follow mode");
  chk_ssi_sync: assert property (s_ssi_pulse |-> O_SEL[cur_q])
    else $error("frame pulse low during frame-sync setup");
  chk_word_size: assert property (I_MASTER && rx_push |-> nrise_q == bits_c)
    else $error("frame length differs from word size");
  chk_slave_sel: assert property (!I_MASTER |-> O_SEL_OE_N == '1)
    else $error("slave drives a select line");
endmodule // spms_top

// [testbench/spms_peer.sv]
/*
  Model of an external chip-select serial slave for the port in master mode.
  Assumes CPOL 0: it samples on rising clock and changes data on falling clock.
*/
`timescale 1ns/1ps
module spms_peer (
  // Pins from the port
  input wire logic i_sck,
  input wire logic i_sel_n,
  input wire logic i_sdo,
  // Reply word and its size
  input wire logic [15:0] i_reply,
  input wire logic [4:0] i_bits,
  // Data line and captured word
  output logic o_sdi,
  output logic [15:0] o_got
);
  logic [15:0] sh;
  initial begin
    o_sdi = 1'b0;
    o_got = 16'h0000;
    sh = 16'h0000;
  end
  always @(negedge i_sel_n) begin
    sh = i_reply << (5'h10 - i_bits);
    o_sdi = sh[15];
  end
  always @(posedge i_sck) begin
    if (!i_sel_n) o_got = {o_got[14:0], i_sdo};
  end
  always @(negedge i_sck) begin
    if (!i_sel_n) begin
      sh = sh << 1;
      o_sdi = sh[15];
    end
  end
  // Released line flips so a stale bit never looks valid
  always @(posedge i_sel_n) o_sdi = ~o_sdi;
endmodule // spms_peer

// [testbench/spms_top_tb.sv]
/*
  Self-checking bench of the serial port: loopback, external slave, overrun.
  Assumes the design files and the peer model are compiled first.
*/
`timescale 1ns/1ps
module spms_top_tb;
  import spms_pkg::*;
  logic clk = 1'b0, srst = 1'b1, en = 1'b0, mst = 1'b1, lpb = 1'b0;
  logic [7:0] pre = 8'h01, div = 8'h03;
  logic [3:0] slv_en = 4'h1, fmt = 4'h0;
  logic [15:0] wsize = 16'h7777;
  logic tx_valid = 1'b0, rx_ready = 1'b0, ovr_clr = 1'b0;
  spms_word_t tx_data = 16'h0000;
  logic [2:0] mask = 3'h0;
  logic tx_ready, rx_valid, overrun, busy, irq, sdo, sdi, sck, sck_oe_n;
  spms_word_t rx_data;
  logic [3:0] sel, sel_oe_n;
  logic [15:0] reply = 16'h0000, got;
  logic [4:0] bits = 5'h10;
  int fs_cycles = 0, cs0_falls = 0;
  logic sel0_q = 1'b1;
  logic ext_sck = 1'b0, ext_sel = 1'b1, ext_sdi = 1'b0;
  int miscompares = 0, n_compared = 0;

  initial forever #5 clk = ~clk;

  // Small FIFOs so the overrun case is short
  spms_top #(.FIFO_DEPTH(2)) u_dut (.I_CORE_CLK(clk), .I_SRST(srst), .I_ENABLE(en),
    .I_MASTER(mst), .I_LOOPBACK(lpb), .I_PRESCALE(pre), .I_DIVISOR(div), .I_SLV_EN(slv_en),
    .I_SLV_FMT(fmt), .I_SLV_WSIZE(wsize), .I_TX_VALID(tx_valid), .I_TX_DATA(tx_data),
    .O_TX_READY(tx_ready), .O_RX_VALID(rx_valid), .O_RX_DATA(rx_data),
    .I_RX_READY(rx_ready), .I_IRQ_MASK(mask), .I_OVR_CLR(ovr_clr), .O_OVERRUN(overrun),
    .O_BUSY(busy), .O_IRQ(irq), .O_SDO(sdo), .I_SDI(mst ? sdi : ext_sdi), .I_SCK(ext_sck),
    .O_SCK(sck), .O_SCK_OE_N(sck_oe_n), .I_SEL0(ext_sel), .O_SEL(sel),
    .O_SEL_OE_N(sel_oe_n));

  spms_peer u_peer (.i_sck(sck), .i_sel_n(sel[0]), .i_sdo(sdo), .i_reply(reply),
    .i_bits(bits), .o_sdi(sdi), .o_got(got));

  // Cycles of frame pulse on select one, and falls of select zero
  always @(posedge clk) begin
    sel0_q <= sel[0];
    if (sel[1] === 1'b1) begin
      fs_cycles <= fs_cycles + 1;
    end
    if (sel[0] === 1'b0 && sel0_q === 1'b1) begin
      cs0_falls <= cs0_falls + 1;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      miscompares++;
    end
  endtask

  task automatic push(input spms_word_t w);
    int i;
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = w;
    for (i = 0; i < 2000 && tx_ready !== 1'b1; i++) @(negedge clk);
    if (i == 2000) begin
      miscompares++;
      end_of_test();
    end
    @(negedge clk);
    tx_valid = 1'b0;
  endtask

  task automatic pop(output spms_word_t d);
    int i;
    for (i = 0; i < 1000 && rx_valid !== 1'b1; i++) @(negedge clk);
    if (i == 1000) begin
      miscompares++;
      end_of_test();
    end
    d = rx_data;
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check(16'(tx_ready), 16'h0001);
    check(16'(rx_valid), 16'h0000);
    check(16'({sck, sck_oe_n, busy}), 16'h0000);
    check(16'({sel, sel_oe_n}), 16'h00F0);
    check(16'(irq), 16'h0001);
  endtask

  task automatic t_loop();
    int sizes[3] = '{4, 9, 16};
    spms_word_t d;
    @(negedge clk);
    lpb = 1'b1;
    pre = 8'h00;
    div = 8'h00;
    foreach (sizes[k]) begin
      repeat (8) @(negedge clk);
      wsize[3:0] = 4'(sizes[k] - 1);
      push(16'hB6D3);
      pop(d);
      check(d, 16'hB6D3 & 16'((32'h1 << sizes[k]) - 1));
    end
  endtask

  // Half period 2 x 3 = 6 cycles: covers the 4-cycle input synchroniser lag
  task automatic t_peer();
    spms_word_t d;
    int fs0, cs0;
    repeat (8) @(negedge clk);
    lpb = 1'b0;
    pre = 8'h02;
    div = 8'h02;
    slv_en = 4'h3;
    fmt = 4'h2;
    wsize = 16'h777B;
    reply = 16'h0A5C;
    bits = 5'h0C;
    fs0 = fs_cycles;
    cs0 = cs0_falls;
    // Slave zero served last, so slave one comes first
    push(16'h0055);
    @(negedge clk);
    check(16'(busy), 16'h0001);
    pop(d);
    check(16'(fs_cycles - fs0), 16'h000C);
    check(16'(cs0_falls - cs0), 16'h0000);
    push(16'h0C3F);
    pop(d);
    check(d, 16'h0A5C);
    check(got & 16'h0FFF, 16'h0C3F);
    check(16'(cs0_falls - cs0), 16'h0001);
    check(16'(fs_cycles - fs0), 16'h000C);
  endtask

  task automatic t_ovr();
    int i;
    spms_word_t d;
    repeat (8) @(negedge clk);
    lpb = 1'b1;
    pre = 8'h00;
    div = 8'h00;
    slv_en = 4'h1;
    fmt = 4'h0;
    wsize = 16'h777F;
    push(16'h1111);
    push(16'h2222);
    push(16'h3333);
    for (i = 0; i < 2000 && overrun !== 1'b1; i++) @(negedge clk);
    check(16'(overrun), 16'h0001);
    mask = 3'h3;
    @(negedge clk);
    check(16'(irq), 16'h0001);
    mask = 3'h7;
    @(negedge clk);
    check(16'(irq), 16'h0000);
    pop(d);
    check(d, 16'h1111);
    pop(d);
    check(d, 16'h2222);
    check(16'(rx_valid), 16'h0000);
    ovr_clr = 1'b1;
    @(negedge clk);
    ovr_clr = 1'b0;
    mask = 3'h6;
    @(negedge clk);
    check(16'({overrun, irq}), 16'h0001);
  endtask

  // External master on select zero, serial clock at a quarter of core clock
  task automatic t_slave();
    spms_word_t d;
    logic [7:0] w;
    w = 8'hA7;
    repeat (8) @(negedge clk);
    mst = 1'b0;
    lpb = 1'b0;
    fmt = 4'h0;
    wsize = 16'h7777;
    repeat (6) @(negedge clk);
    check(16'({sck_oe_n, sel_oe_n}), 16'h001F);
    ext_sel = 1'b0;
    for (int b = 7; b >= 0; b--) begin
      ext_sdi = w[b];
      repeat (2) @(negedge clk);
      ext_sck = 1'b1;
      repeat (2) @(negedge clk);
      ext_sck = 1'b0;
    end
    repeat (2) @(negedge clk);
    ext_sel = 1'b1;
    pop(d);
    check(d, 16'h00A7);
  endtask

  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    en = 1'b1;
    t_reset();
    t_loop();
    t_peer();
    t_ovr();
    t_slave();
    end_of_test();
  end
endmodule // spms_top_tb
